// ### hw/gst_timer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - sixteen-bit counter, byte writes load directly
// - source bit picks instruction clock or pin
// - internal source counts prescaled instruction cycles
// - external source counts input rising edges
// - first rising edge needs prior falling edge
// - prescaler divides input by 1,2,4,8
// - prescaler hidden, cleared on count writes
// - bypass bit skips synchroniser, else synchronised
// - async mode counts in sleep, overflow wakes
// - crystal enable starts sleep-proof crystal source
// - crystal forces pin directions one, data zero
// - mode switch may drop or add one
// - rollover to zero sets overflow flag
// - prescale codes 00,01,10,11 give 1,2,4,8
// - counts only while timer_on set
module gst_timer (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   input  wire logic       ext_count_input,
   input  wire logic       crystal_clk,
   input  wire logic       sleep,
   input  wire logic       port_dir_a,
   input  wire logic       port_dir_b,
   input  wire logic       port_data_a,
   input  wire logic       port_data_b,
   output logic            osc_pin_a_direction,
   output logic            osc_pin_b_direction,
   output logic            osc_pin_a_data,
   output logic            osc_pin_b_data,
   output logic            crystal_osc_run,
   output logic            irq
);
   import gst_pkg::*;

   // ************************************************************
   // state
   // ************************************************************
   logic [15:0] count;
   logic [7:0]  timer_control;
   logic [7:0]  status;
   logic [7:0]  mask;
   logic [1:0]  instr_div;
   logic        sync_p1, sync_p2;

   logic [15:0] next_count;
   logic [7:0]  next_control, next_status, next_mask, next_rdata;
   logic [1:0]  next_div;
   logic        next_p1, next_p2;
   logic        next_dir_a, next_dir_b, next_data_a, next_data_b;

   logic       timer_on, source_select, sync_bypass, crystal_osc_enable;
   gst_presc_t prescale_select;
   logic       wr_low, wr_high, wr_count, rd_status;
   logic       instr_tick, ext_rise, src_tick, run_ok, presc_pulse;
   logic       inc, rollover;
   logic [2:0] presc_cnt;

   assign timer_on           = timer_control[CTL_TIMER_ON];
   assign source_select      = timer_control[CTL_SOURCE_SEL];
   assign sync_bypass        = timer_control[CTL_SYNC_BYP];
   assign crystal_osc_enable = timer_control[CTL_XTAL_EN];
   assign prescale_select    = gst_presc_t'(timer_control[CTL_PRESC_HI:CTL_PRESC_LO]);

   assign wr_low    = wr && (addr == ADDR_COUNT_LOW);
   assign wr_high   = wr && (addr == ADDR_COUNT_HIGH);
   assign wr_count  = wr_low || wr_high;
   assign rd_status = rd && (addr == ADDR_STATUS);

   // ************************************************************
   // clock source and prescaler
   // ************************************************************
   assign instr_tick = (instr_div == INSTR_LAST);

   // crystal keeps running in sleep regardless of timer_on
   assign crystal_osc_run = crystal_osc_enable;

   // only async external counting survives sleep
   assign run_ok   = timer_on && (!sleep || (source_select && sync_bypass));
   assign src_tick = run_ok && (source_select ? ext_rise : instr_tick);

   // one sampler for both sources; flipping the enable mid-run can fake an edge
   gst_edge_detect u_edge (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin     (crystal_osc_enable ? crystal_clk : ext_count_input),
      .arm_en  (timer_on && source_select),
      .rise    (ext_rise)
   );

   gst_prescaler u_presc (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .tick    (src_tick),
      .clear   (wr_count),
      .sel     (prescale_select),
      .pulse   (presc_pulse),
      .cnt     (presc_cnt)
   );

   // ************************************************************
   // counter
   // ************************************************************
   always_comb begin
      next_div = 2'(instr_div + 2'h1);
      // synchronised path adds two stages; a mode switch may drop
      // or repeat a pulse held in them, which is tolerated
      next_p1  = presc_pulse && !wr_count;
      next_p2  = sync_p1 && !wr_count;
      if (source_select && !sync_bypass) begin
         inc = sync_p2 && run_ok;
      end else begin
         inc = presc_pulse;
      end
      rollover   = inc && (count == COUNT_MAX);
      next_count = count;
      if (inc) begin
         next_count = 16'(count + 16'h0001);
      end
      if (wr_low) begin
         next_count[7:0] = wdata;
      end
      if (wr_high) begin
         next_count[15:8] = wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         count     <= COUNT_RESET;
         instr_div <= 2'h0;
         sync_p1   <= 1'b0;
         sync_p2   <= 1'b0;
      end else begin
         count     <= next_count;
         instr_div <= next_div;
         sync_p1   <= next_p1;
         sync_p2   <= next_p2;
      end
   end

   // ************************************************************
   // registers, interrupt and pin override
   // ************************************************************
   always_comb begin
      next_control = timer_control;
      next_mask    = mask;
      next_status  = status;
      if (wr && addr == ADDR_CONTROL) begin
         next_control = wdata & CTL_WR_MASK;
      end
      if (wr && addr == ADDR_MASK) begin
         next_mask = wdata & 8'h01;
      end
      if (rd_status) begin
         next_status = 8'h00;
      end
      // set beats the read-clear
      if (rollover) begin
         next_status[STAT_OVERFLOW] = 1'b1;
      end
      // no latch on the high byte; a running count may carry between reads
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            ADDR_COUNT_LOW:  next_rdata = count[7:0];
            ADDR_COUNT_HIGH: next_rdata = count[15:8];
            ADDR_CONTROL:    next_rdata = timer_control;
            ADDR_STATUS:     next_rdata = status;
            ADDR_MASK:       next_rdata = mask;
            ADDR_PINS:       next_rdata = {4'h0, osc_pin_b_direction, osc_pin_a_direction,
                                           osc_pin_b_data, osc_pin_a_data};
            default:         next_rdata = 8'h00;
         endcase
      end
      next_dir_a  = port_dir_a || crystal_osc_enable;
      next_dir_b  = port_dir_b || crystal_osc_enable;
      next_data_a = port_data_a && !crystal_osc_enable;
      next_data_b = port_data_b && !crystal_osc_enable;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         timer_control       <= CONTROL_RESET;
         mask                <= MASK_RESET;
         status              <= 8'h00;
         rdata               <= 8'h00;
         osc_pin_a_direction <= 1'b0;
         osc_pin_b_direction <= 1'b0;
         osc_pin_a_data      <= 1'b0;
         osc_pin_b_data      <= 1'b0;
      end else begin
         timer_control       <= next_control;
         mask                <= next_mask;
         status              <= next_status;
         rdata               <= next_rdata;
         osc_pin_a_direction <= next_dir_a;
         osc_pin_b_direction <= next_dir_b;
         osc_pin_a_data      <= next_data_a;
         osc_pin_b_data      <= next_data_b;
      end
   end

   assign irq = |(status & mask);

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence s_sync_pulse;
      presc_pulse && source_select && !sync_bypass && !wr_count;
   endsequence
   sequence s_sync_steady;
      (source_select && !sync_bypass && run_ok && !wr_count) [*3];
   endsequence

   property p_load_low;
      wr_low |=> count[7:0] == $past(wdata);
   endproperty
   a_load_low: assert property (p_load_low) else $error("low byte not loaded");

   property p_load_high;
      wr_high |=> count[15:8] == $past(wdata);
   endproperty
   a_load_high: assert property (p_load_high) else $error("high byte not loaded");

   property p_hold_off;
      (!timer_on && !wr_count) |=> count == $past(count);
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("counted while off");

   property p_rollover;
      (count == COUNT_MAX && inc && !wr_count) |=> count == COUNT_RESET && status[STAT_OVERFLOW];
   endproperty
   a_rollover: assert property (p_rollover) else $error("rollover wrong");

   property p_irq;
      (rollover && mask[STAT_OVERFLOW]) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("overflow did not interrupt");

   property p_sleep_sync;
      (sleep && !(source_select && sync_bypass)) |-> !inc;
   endproperty
   a_sleep_sync: assert property (p_sleep_sync) else $error("counted in sleep");

   property p_presc_clear;
      wr_count |=> presc_cnt == 3'h0;
   endproperty
   a_presc_clear: assert property (p_presc_clear) else $error("prescaler kept");

   property p_sync_delay;
      (s_sync_pulse ##0 s_sync_steady) |-> inc;
   endproperty
   a_sync_delay: assert property (p_sync_delay) else $error("sync path delay wrong");

   property p_pin_force;
      crystal_osc_enable |=> osc_pin_a_direction && osc_pin_b_direction
                             && !osc_pin_a_data && !osc_pin_b_data;
   endproperty
   a_pin_force: assert property (p_pin_force) else $error("pins not forced");

   property p_int_rate;
      (timer_on && !source_select && !sleep && inc) |-> $past(instr_div) == 2'h3 || instr_tick;
   endproperty
   a_int_rate: assert property (p_int_rate) else $error("internal count off tick");

   property p_bypass_now;
      (source_select && sync_bypass && presc_pulse) |=> count == 16'($past(count) + 16'h0001);
   endproperty
   a_bypass_now: assert property (p_bypass_now) else $error("bypass count late");

   property p_step_one;
      !wr_count |=> count == $past(count) || count == 16'($past(count) + 16'h0001);
   endproperty
   a_step_one: assert property (p_step_one) else $error("count jumped");

   property p_rd_clear;
      (rd_status && !rollover) |=> !status[STAT_OVERFLOW];
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("overflow flag kept");

   // reads never reach the prescaler
   property p_hidden;
      (rd && addr > ADDR_PINS) |=> rdata == 8'h00;
   endproperty
   a_hidden: assert property (p_hidden) else $error("unmapped read not zero");

   property p_int_step;
      (timer_on && !source_select && !sleep && !wr_count && instr_tick
       && prescale_select == GST_DIV1) |-> inc;
   endproperty
   a_int_step: assert property (p_int_step) else $error("internal tick missed");
endmodule // gst_timer

// ### hw/gst_pkg.sv
package gst_pkg;
   // ************************************************************
   // register map (byte wide)
   // ************************************************************
   localparam logic [2:0] ADDR_COUNT_LOW  = 3'h0;
   localparam logic [2:0] ADDR_COUNT_HIGH = 3'h1;
   localparam logic [2:0] ADDR_CONTROL    = 3'h2;
   localparam logic [2:0] ADDR_STATUS     = 3'h3;
   localparam logic [2:0] ADDR_MASK       = 3'h4;
   localparam logic [2:0] ADDR_PINS       = 3'h5;

   // ************************************************************
   // timer_control field positions
   // ************************************************************
   localparam int CTL_TIMER_ON   = 0;
   localparam int CTL_SOURCE_SEL = 1;
   localparam int CTL_SYNC_BYP   = 2;
   localparam int CTL_XTAL_EN    = 3;
   localparam int CTL_PRESC_LO   = 4;
   localparam int CTL_PRESC_HI   = 5;
   localparam logic [7:0] CTL_WR_MASK = 8'h3f;

   // status / mask bit
   localparam int STAT_OVERFLOW = 0;

   // ************************************************************
   // reset values and counts
   // ************************************************************
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [7:0]  MASK_RESET    = 8'h00;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_MAX     = 16'hffff;
   // instruction cycle is four oscillator cycles
   localparam int INSTR_DIV = 4;
   localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

   typedef enum logic [1:0] {
      GST_DIV1, GST_DIV2, GST_DIV4, GST_DIV8
   } gst_presc_t;

   // mask of prescale bits that must all be one for an output pulse
   function automatic logic [2:0] gst_presc_mask(input logic [1:0] sel);
      case (sel)
         2'h0:    gst_presc_mask = 3'h0;
         2'h1:    gst_presc_mask = 3'h1;
         2'h2:    gst_presc_mask = 3'h3;
         default: gst_presc_mask = 3'h7;
      endcase
   endfunction
endpackage

// ### hw/gst_edge_detect.sv
`timescale 1ns/1ps
// ************************************************************
// pin sampler and armed rising-edge detector
// ************************************************************
module gst_edge_detect (
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic pin,
   input  wire logic arm_en,
   output logic      rise
);
   import gst_pkg::*;

   logic s1, s2, s3, level, armed;
   logic next_level, next_armed;
   logic stable;

   assign stable = (s2 == s3);

   always_comb begin
      next_level = level;
      next_armed = armed;
      rise       = 1'b0;
      if (stable && !s3 && level) begin
         next_level = 1'b0;
         next_armed = 1'b1;
      end else if (stable && s3 && !level) begin
         next_level = 1'b1;
         rise       = armed;
      end
      if (!arm_en) begin
         next_armed = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s1    <= 1'b0;
         s2    <= 1'b0;
         s3    <= 1'b0;
         level <= 1'b0;
         armed <= 1'b0;
      end else begin
         s1    <= pin;
         s2    <= s1;
         s3    <= s2;
         level <= next_level;
         armed <= next_armed;
      end
   end

   property p_rise_armed;
      @(posedge ref_clk) disable iff (!rst_n) rise |-> armed && $past(s3) == 1'b0;
   endproperty
   a_rise_armed: assert property (p_rise_armed) else $error("edge counted before fall");
endmodule // gst_edge_detect

// ### hw/gst_prescaler.sv
`timescale 1ns/1ps
// ************************************************************
// 1/2/4/8 prescaler, hidden from software
// ************************************************************
module gst_prescaler (
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic                tick,
   input  wire logic                clear,
   input  wire gst_pkg::gst_presc_t sel,
   output logic                     pulse,
   output logic [2:0]               cnt
);
   import gst_pkg::*;

   logic [2:0] next_cnt;
   logic [2:0] msk;

   always_comb begin
      msk      = gst_presc_mask(sel);
      pulse    = tick && !clear && ((cnt & msk) == msk);
      next_cnt = cnt;
      if (clear) begin
         next_cnt = 3'h0;
      end else if (tick) begin
         next_cnt = pulse ? 3'h0 : 3'(cnt + 3'h1);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt <= 3'h0;
      end else begin
         cnt <= next_cnt;
      end
   end

   property p_div8;
      @(posedge ref_clk) disable iff (!rst_n) (pulse && sel == GST_DIV8) |-> cnt == 3'h7;
   endproperty
   a_div8: assert property (p_div8) else $error("divide by eight pulsed early");

   property p_clear;
      @(posedge ref_clk) disable iff (!rst_n) clear |=> cnt == 3'h0;
   endproperty
   a_clear: assert property (p_clear) else $error("prescaler not cleared");
endmodule // gst_prescaler

// ### sim/gst_ext_clk_model.sv
`timescale 1ns/1ps
// ************************************************************
// far-side count source, stands low while idle
// ************************************************************
module gst_ext_clk_model (
   input  wire logic       ref_clk,
   input  wire logic       run,
   input  wire logic [3:0] half,
   output logic            clk_out
);
   logic [3:0] cnt;
   initial begin
      cnt     = 4'h0;
      clk_out = 1'b0;
   end
   always @(posedge ref_clk) begin
      if (!run) begin
         cnt     <= 4'h0;
         clk_out <= 1'b0;
      end else if (cnt == half - 4'h1) begin
         cnt     <= 4'h0;
         clk_out <= ~clk_out;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule // gst_ext_clk_model

// ### sim/gst_timer_tb.sv
`timescale 1ns/1ps
module gst_timer_tb;
   import gst_pkg::*;
   typedef struct packed {
      logic [2:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } gst_row_t;
   logic        ref_clk, rst_n, wr, rd, sleep, ext_run, xtal_run, src_q, use_xtal;
   logic [2:0]  addr;
   logic [7:0]  wdata, rdata, v;
   logic        port_dir_a, port_dir_b, port_data_a, port_data_b;
   logic        ext_count_input, crystal_clk, crystal_osc_run, irq;
   logic        osc_pin_a_direction, osc_pin_b_direction, osc_pin_a_data, osc_pin_b_data;
   logic [15:0] got;
   int          bad_count, n_tests, rises;
   gst_row_t    rows [8];

   gst_timer gst_timer_inst (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .ext_count_input(ext_count_input),
      .crystal_clk(crystal_clk), .sleep(sleep), .port_dir_a(port_dir_a),
      .port_dir_b(port_dir_b), .port_data_a(port_data_a), .port_data_b(port_data_b),
      .osc_pin_a_direction(osc_pin_a_direction), .osc_pin_b_direction(osc_pin_b_direction),
      .osc_pin_a_data(osc_pin_a_data), .osc_pin_b_data(osc_pin_b_data),
      .crystal_osc_run(crystal_osc_run), .irq(irq));
   gst_ext_clk_model ext_src_inst (.ref_clk(ref_clk), .run(ext_run), .half(4'h5),
      .clk_out(ext_count_input));
   gst_ext_clk_model xtal_src_inst (.ref_clk(ref_clk), .run(xtal_run), .half(4'h3),
      .clk_out(crystal_clk));

   always #2 ref_clk = ~ref_clk;

   // edges of whichever source the timer should be following
   always @(posedge ref_clk) begin
      // choice held between runs, so stopping both sources fakes no edge
      src_q <= use_xtal ? crystal_clk : ext_count_input;
      if ((use_xtal ? crystal_clk : ext_count_input) && !src_q) rises <= rises + 1;
   end

   // ************************************************************
   // bus and compare tasks
   // ************************************************************
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rd16(output logic [15:0] c);
      rd_reg(ADDR_COUNT_LOW, c[7:0]);
      rd_reg(ADDR_COUNT_HIGH, c[15:8]);
   endtask
   task automatic fail(input logic [15:0] g, input logic [15:0] e);
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
   endtask
   task automatic chk8(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) fail({8'h0, g}, {8'h0, e});
   endtask
   task automatic chk1(input logic g, input logic e);
      n_tests++;
      if (g !== e) fail({15'h0, g}, {15'h0, e});
   endtask
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) fail(g, e);
   endtask
   // internal runs start at an unknown instruction phase, so allow one
   task automatic chk_near(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if ((^g === 1'bx) || (g > e + 16'h1) || (g + 16'h1 < e)) fail(g, e);
   endtask

   // preload, run the far side, stop, then read back
   task automatic run_ext(input logic [7:0] ctl, input logic [15:0] start, input logic live);
      logic [15:0] e;
      wr_reg(ADDR_CONTROL, ctl & 8'h08);
      wr_reg(ADDR_COUNT_HIGH, start[15:8]);
      wr_reg(ADDR_COUNT_LOW, start[7:0]);
      wr_reg(ADDR_CONTROL, ctl);
      use_xtal = ctl[CTL_XTAL_EN];
      rises    = 0;
      @(posedge ref_clk);
      ext_run  <= 1'b1;
      xtal_run <= ctl[CTL_XTAL_EN];
      repeat (160) @(posedge ref_clk);
      ext_run  <= 1'b0;
      xtal_run <= 1'b0;
      repeat (12) @(posedge ref_clk);
      wr_reg(ADDR_CONTROL, ctl & 8'hfe);
      rd16(got);
      e = live ? start + 16'((rises - 1) >> ctl[5:4]) : start;
      chk16(got, e);
   endtask

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      repeat (8000) @(posedge ref_clk);
      bad_count++;
      print_verdict();
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      ref_clk = 0;
      rst_n = 0;
      wr = 0;
      rd = 0;
      addr = 3'h0;
      wdata = 8'h00;
      sleep = 0;
      ext_run = 0;
      xtal_run = 0;
      src_q = 0;
      use_xtal = 0;
      rises = 0;
      port_dir_a = 0;
      port_dir_b = 0;
      port_data_a = 1;
      port_data_b = 1;
      bad_count = 0;
      n_tests = 0;
      rows = '{'{ADDR_CONTROL, 8'h3e, 8'h3e}, '{ADDR_CONTROL, 8'hc0, 8'h00},
               '{ADDR_MASK, 8'hff, 8'h01}, '{ADDR_MASK, 8'h00, 8'h00},
               '{ADDR_COUNT_LOW, 8'h5a, 8'h5a}, '{ADDR_COUNT_HIGH, 8'ha5, 8'ha5},
               '{3'h6, 8'hff, 8'h00}, '{3'h7, 8'h77, 8'h00}};
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_reg(ADDR_CONTROL, v);
      chk8(v, CONTROL_RESET);
      rd_reg(ADDR_STATUS, v);
      chk8(v, 8'h00);
      rd_reg(ADDR_MASK, v);
      chk8(v, MASK_RESET);
      rd16(got);
      chk16(got, COUNT_RESET);
      rd_reg(ADDR_PINS, v);
      chk8(v, 8'h03);
      chk1(irq, 1'b0);
      foreach (rows[i]) begin
         wr_reg(rows[i].a, rows[i].d);
         rd_reg(rows[i].a, v);
         chk8(v, rows[i].e);
      end
      // internal source, every prescale code
      for (int s = 0; s < 4; s++) begin
         wr_reg(ADDR_CONTROL, 8'h00);
         wr_reg(ADDR_COUNT_HIGH, 8'h00);
         wr_reg(ADDR_COUNT_LOW, 8'h00);
         wr_reg(ADDR_CONTROL, {2'h0, 2'(s), 4'h1});
         repeat (256) @(posedge ref_clk);
         wr_reg(ADDR_CONTROL, 8'h00);
         rd16(got);
         chk_near(got, 16'(64 >> s));
      end
      repeat (40) @(posedge ref_clk);
      rd16(got);
      chk_near(got, 16'h0008);
      // external source, synchronised and bypassed
      run_ext(8'h03, 16'h0100, 1'b1);
      run_ext(8'h07, 16'h0200, 1'b1);
      run_ext(8'h13, 16'h0300, 1'b1);
      run_ext(8'h37, 16'h0400, 1'b1);
      run_ext(8'h27, 16'h0500, 1'b1);
      // crystal started and left to settle before the timer runs
      wr_reg(ADDR_CONTROL, 8'h08);
      repeat (20) @(posedge ref_clk);
      chk1(crystal_osc_run, 1'b1);
      chk1(osc_pin_a_direction & osc_pin_b_direction, 1'b1);
      chk1(osc_pin_a_data | osc_pin_b_data, 1'b0);
      rd_reg(ADDR_PINS, v);
      chk8(v, 8'h0c);
      run_ext(8'h0f, 16'h0600, 1'b1);
      // overflow, masked then unmasked
      wr_reg(ADDR_CONTROL, 8'h00);
      wr_reg(ADDR_COUNT_HIGH, 8'hff);
      wr_reg(ADDR_COUNT_LOW, 8'hfe);
      wr_reg(ADDR_CONTROL, 8'h01);
      repeat (40) @(posedge ref_clk);
      wr_reg(ADDR_CONTROL, 8'h00);
      chk1(irq, 1'b0);
      rd16(got);
      chk_near(got, 16'h0008);
      wr_reg(ADDR_MASK, 8'h01);
      #1 chk1(irq, 1'b1);
      rd_reg(ADDR_STATUS, v);
      chk8(v, 8'h01);
      @(posedge ref_clk);
      #1 chk1(irq, 1'b0);
      rd_reg(ADDR_STATUS, v);
      chk8(v, 8'h00);
      // sleep: only the bypassed external path keeps counting
      @(posedge ref_clk);
      sleep <= 1'b1;
      run_ext(8'h07, 16'hfffe, 1'b1);
      chk1(irq, 1'b1);
      run_ext(8'h03, 16'h1234, 1'b0);
      @(posedge ref_clk);
      sleep <= 1'b0;
      rd_reg(ADDR_STATUS, v);
      chk8(v, 8'h01);
      // reset in mid-run
      wr_reg(ADDR_CONTROL, 8'h01);
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd_reg(ADDR_CONTROL, v);
      chk8(v, CONTROL_RESET);
      chk1(irq, 1'b0);
      print_verdict();
   end
endmodule // gst_timer_tb
